// ===== cbb_exec_unit.sv
// Execution unit for conditional branches and bit operations,
// with status flags, program counter, register file and I/O space.
// Assumes a classic Wishbone master on clk_sys, same clock domain.
`timescale 1ns/100ps
`include "cbb_defines.svh"

module cbb_exec_unit #(
  parameter int PC_W = 16,
  parameter int RF_N = 32,
  parameter int IO_N = 32
) (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [11:0]       wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic      [PC_W-1:0]   pc_o,
  output logic      [7:0]        status_flags_register_o,
  output logic                   busy_o
);

  // Refuse sizes the index fields cannot serve
  if (PC_W < 8 || PC_W > 16 || RF_N < 1 || RF_N > 32 ||
      IO_N < 1 || IO_N > 32) begin : g_chk
    $error("cbb_exec_unit: unsupported parameter values");
  end

  logic                   ack_ff;
  logic [31:0]            dat_ff;
  logic [7:0]             status_flags_register_ff;
  logic [PC_W-1:0]        pc_ff;
  logic [7:0]             rf_ff [RF_N];
  logic [7:0]             io_ff [IO_N];
  cbb_pkg::cbb_cmd_t      cmd_ff;
  cbb_pkg::cbb_state_t    st_ff;
  cbb_pkg::cbb_state_t    nxt_st;
  logic                   busy_ff;
  logic                   taken_ff;

  logic                   req;
  logic                   wr_go;
  logic                   sw_ok;
  logic [3:0]             win;
  logic [4:0]             widx;
  logic                   exec;

  // Execution results
  logic                   taken;
  logic                   long_op;
  logic [2:0]             fidx;
  logic                   want;
  logic [7:0]             opnd;
  logic [7:0]             res;
  logic                   c_out;
  logic                   shift_op;
  logic [7:0]             nxt_status_flags_register;
  logic                   wr_rf;
  logic                   wr_io;
  logic [PC_W-1:0]        koff;

  assign wb_dat_o = dat_ff;
  assign wb_ack_o = ack_ff;
  assign pc_o     = pc_ff;
  assign status_flags_register_o   = status_flags_register_ff;
  assign busy_o   = busy_ff;

  // Bus decode; a write lands on the edge that sees ack high
  assign req   = wb_cyc_i & wb_stb_i;
  assign wr_go = req & wb_we_i & ack_ff;
  assign sw_ok = wr_go & (st_ff == cbb_pkg::ST_IDLE);
  assign win   = wb_adr_i[11:8];
  assign widx  = wb_adr_i[6:2];
  assign exec  = (st_ff == cbb_pkg::ST_EXEC);

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // Read data captured with the ack; unmapped reads give zero
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dat_ff <= 32'h0000_0000;
    end else if (req & ~ack_ff) begin
      dat_ff <= 32'h0000_0000;
      if (win == `CBB_WIN_RF && 32'(widx) < RF_N) begin
        dat_ff[7:0] <= rf_ff[widx];
      end else if (win == `CBB_WIN_IO && 32'(widx) < IO_N) begin
        dat_ff[7:0] <= io_ff[widx];
      end else if (win == `CBB_WIN_REGS) begin
        unique case (wb_adr_i)
          `CBB_OFF_CMD:  dat_ff <= cmd_ff;
          `CBB_OFF_STATUS_FLAGS_REGISTER: dat_ff[7:0] <= status_flags_register_ff;
          `CBB_OFF_PC:   dat_ff[PC_W-1:0] <= pc_ff;
          `CBB_OFF_STAT: begin
            dat_ff[`CBB_STAT_BUSY]  <= busy_ff;
            dat_ff[`CBB_STAT_TAKEN] <= taken_ff;
          end
          default: dat_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Branch condition: flag index and the level that takes it;
  // odd codes test the cleared sense, except the lower pair
  always_comb begin
    fidx = `CBB_F_C;
    want = ~cmd_ff.op[0];
    unique case (cmd_ff.op)
      cbb_pkg::branch_flag_set_indexed,
      cbb_pkg::branch_flag_clear_indexed: fidx = cmd_ff.sel;
      cbb_pkg::branch_on_equal,
      cbb_pkg::branch_on_unequal: fidx = `CBB_F_Z;
      cbb_pkg::branch_carry_one,
      cbb_pkg::branch_carry_zero: fidx = `CBB_F_C;
      cbb_pkg::branch_same_or_higher,
      cbb_pkg::branch_lower: begin
        fidx = `CBB_F_C;
        want = cmd_ff.op[0];
      end
      cbb_pkg::branch_negative,
      cbb_pkg::branch_positive: fidx = `CBB_F_N;
      cbb_pkg::branch_halfcarry_one,
      cbb_pkg::branch_halfcarry_zero: fidx = `CBB_F_H;
      cbb_pkg::branch_transfer_one,
      cbb_pkg::branch_transfer_zero: fidx = `CBB_F_T;
      cbb_pkg::branch_overflow_one,
      cbb_pkg::branch_overflow_zero: fidx = `CBB_F_V;
      cbb_pkg::branch_irq_enabled,
      cbb_pkg::branch_irq_disabled: fidx = `CBB_F_I;
      default: fidx = `CBB_F_C;
    endcase
  end

  // Taken decision; the signed pair tests N xor V
  always_comb begin
    if (cmd_ff.op == cbb_pkg::branch_signed_ge) begin
      taken = ~(status_flags_register_ff[`CBB_F_N] ^ status_flags_register_ff[`CBB_F_V]);
    end else if (cmd_ff.op == cbb_pkg::branch_signed_lt) begin
      taken = status_flags_register_ff[`CBB_F_N] ^ status_flags_register_ff[`CBB_F_V];
    end else if (cmd_ff.op <= cbb_pkg::branch_irq_disabled) begin
      taken = (status_flags_register_ff[fidx] == want);
    end else begin
      taken = 1'b0;
    end
  end

  // Shifts, rotates, bit load and flag forcing
  always_comb begin
    opnd     = (32'(cmd_ff.idx) < RF_N) ? rf_ff[cmd_ff.idx] : 8'h00;
    res      = opnd;
    c_out    = status_flags_register_ff[`CBB_F_C];
    shift_op = 1'b1;
    wr_rf    = 1'b0;
    wr_io    = 1'b0;
    nxt_status_flags_register = status_flags_register_ff;
    unique case (cmd_ff.op)
      cbb_pkg::shift_left_logical: begin
        res   = {opnd[6:0], 1'b0};
        c_out = opnd[7];
      end
      cbb_pkg::shift_right_logical: begin
        res   = {1'b0, opnd[7:1]};
        c_out = opnd[0];
      end
      cbb_pkg::rotate_left_carry: begin
        res   = {opnd[6:0], status_flags_register_ff[`CBB_F_C]};
        c_out = opnd[7];
      end
      cbb_pkg::rotate_right_carry: begin
        res   = {status_flags_register_ff[`CBB_F_C], opnd[7:1]};
        c_out = opnd[0];
      end
      cbb_pkg::shift_right_arith: begin
        res   = {opnd[7], opnd[7:1]};
        c_out = opnd[0];
      end
      default: shift_op = 1'b0;
    endcase
    if (shift_op) begin
      wr_rf                 = 1'b1;
      nxt_status_flags_register[`CBB_F_Z]    = (res == 8'h00);
      nxt_status_flags_register[`CBB_F_C]    = c_out;
      nxt_status_flags_register[`CBB_F_N]    = res[7];
      nxt_status_flags_register[`CBB_F_V]    = res[7] ^ c_out;
    end
    unique case (cmd_ff.op)
      cbb_pkg::io_bit_set: wr_io = 1'b1;
      cbb_pkg::bit_to_transfer_flag:
        nxt_status_flags_register[`CBB_F_T] = opnd[cmd_ff.sel];
      cbb_pkg::transfer_flag_to_bit: begin
        res[cmd_ff.sel] = status_flags_register_ff[`CBB_F_T];
        wr_rf           = 1'b1;
      end
      cbb_pkg::carry_force_one:      nxt_status_flags_register[`CBB_F_C] = 1'b1;
      cbb_pkg::carry_force_zero:     nxt_status_flags_register[`CBB_F_C] = 1'b0;
      cbb_pkg::negative_force_one:   nxt_status_flags_register[`CBB_F_N] = 1'b1;
      cbb_pkg::negative_force_zero:  nxt_status_flags_register[`CBB_F_N] = 1'b0;
      cbb_pkg::zero_flag_force_one:  nxt_status_flags_register[`CBB_F_Z] = 1'b1;
      cbb_pkg::zero_flag_force_zero: nxt_status_flags_register[`CBB_F_Z] = 1'b0;
      cbb_pkg::irq_global_on:        nxt_status_flags_register[`CBB_F_I] = 1'b1;
      cbb_pkg::irq_global_off:       nxt_status_flags_register[`CBB_F_I] = 1'b0;
      cbb_pkg::sign_force_one:       nxt_status_flags_register[`CBB_F_S] = 1'b1;
      default: ;
    endcase
  end

  // Second cycle for taken branches and the I/O bit set
  assign long_op = taken | wr_io;
  // Sign-extended offset
  assign koff = {{(PC_W-7){cmd_ff.k[6]}}, cmd_ff.k};

  // Sequencer: idle, one execute cycle, optional hold cycle
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      cbb_pkg::ST_IDLE:
        if (sw_ok && wb_adr_i == `CBB_OFF_CMD && &wb_sel_i[2:0]) begin
          nxt_st = cbb_pkg::ST_EXEC;
        end
      cbb_pkg::ST_EXEC:
        nxt_st = long_op ? cbb_pkg::ST_HOLD : cbb_pkg::ST_IDLE;
      cbb_pkg::ST_HOLD: nxt_st = cbb_pkg::ST_IDLE;
      default:          nxt_st = cbb_pkg::ST_IDLE;
    endcase
  end

  // State, busy flag and the captured command
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_ff   <= cbb_pkg::ST_IDLE;
      busy_ff <= 1'b0;
      cmd_ff  <= '0;
    end else begin
      st_ff   <= nxt_st;
      busy_ff <= (nxt_st != cbb_pkg::ST_IDLE);
      if (st_ff == cbb_pkg::ST_IDLE && nxt_st == cbb_pkg::ST_EXEC) begin
        cmd_ff <= cbb_pkg::cbb_cmd_t'(wb_dat_i);
      end
    end
  end

  // Outcome of the last executed command, zero for non-branches, shown in the status word
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      taken_ff <= 1'b0;
    end else if (exec) begin
      taken_ff <= taken;
    end
  end

  // Status flags: execution, else a software write when idle
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      status_flags_register_ff <= `CBB_STATUS_FLAGS_REGISTER_RST;
    end else if (exec) begin
      status_flags_register_ff <= nxt_status_flags_register;
    end else if (sw_ok && wb_adr_i == `CBB_OFF_STATUS_FLAGS_REGISTER && wb_sel_i[0]) begin
      status_flags_register_ff <= wb_dat_i[7:0];
    end
  end

  // Program counter: next word, or next word plus offset if taken
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pc_ff <= '0;
    end else if (exec) begin
      pc_ff <= taken ? PC_W'(pc_ff + koff + 1'b1)
                     : PC_W'(pc_ff + 1'b1);
    end else if (sw_ok && wb_adr_i == `CBB_OFF_PC) begin
      if (wb_sel_i[0]) begin
        pc_ff[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        pc_ff[PC_W-1:8] <= wb_dat_i[PC_W-1:8];
      end
    end
  end

  // Register file and I/O space, one RF entry per step below RF_N, one I/O entry per step below IO_N
  for (genvar gi = 0; gi < 32; gi++) begin : g_ent
    if (gi < RF_N) begin : g_rf
      always_ff @(posedge clk_sys) begin
        if (!rstn) begin
          rf_ff[gi] <= `CBB_DATA_RST;
        end else if (exec) begin
          if (wr_rf && cmd_ff.idx == 5'(gi)) begin
            rf_ff[gi] <= res;
          end
        end else if (sw_ok && win == `CBB_WIN_RF &&
                     widx == 5'(gi) && wb_sel_i[0]) begin
          rf_ff[gi] <= wb_dat_i[7:0];
        end
      end
    end
    if (gi < IO_N) begin : g_io
      always_ff @(posedge clk_sys) begin
        if (!rstn) begin
          io_ff[gi] <= `CBB_DATA_RST;
        end else if (exec) begin
          if (wr_io && cmd_ff.idx == 5'(gi)) begin
            io_ff[gi][cmd_ff.sel] <= 1'b1;
          end
        end else if (sw_ok && win == `CBB_WIN_IO &&
                     widx == 5'(gi) && wb_sel_i[0]) begin
          io_ff[gi] <= wb_dat_i[7:0];
        end
      end
    end
  end

endmodule

// ===== cbb_defines.svh
// Offsets, flag positions, reset values and cycle counts of the
// branch and bit-operation unit.
// Assumes inclusion by bare name from the module.
`ifndef CBB_DEFINES_SVH
`define CBB_DEFINES_SVH

// Word offsets on the bus (byte addresses)
`define CBB_OFF_CMD   12'h000
`define CBB_OFF_STATUS_FLAGS_REGISTER  12'h004
`define CBB_OFF_PC    12'h008
`define CBB_OFF_STAT  12'h00C
// Windows, selected by address bits 11:8
`define CBB_WIN_REGS  4'h0
`define CBB_WIN_RF    4'h1
`define CBB_WIN_IO    4'h2

// Status flag bit positions
`define CBB_F_C 3'h0
`define CBB_F_Z 3'h1
`define CBB_F_N 3'h2
`define CBB_F_V 3'h3
`define CBB_F_S 3'h4
`define CBB_F_H 3'h5
`define CBB_F_T 3'h6
`define CBB_F_I 3'h7

// Status word bit positions
`define CBB_STAT_BUSY  0
`define CBB_STAT_TAKEN 1

// Reset values
`define CBB_STATUS_FLAGS_REGISTER_RST 8'h00
`define CBB_DATA_RST 8'h00

// Execution cycles: short ops and taken branches / I/O bit set
`define CBB_CYC_SHORT 1
`define CBB_CYC_LONG  2

`endif

// ===== cbb_pkg.sv
// Types shared by the branch and bit-operation unit.
package cbb_pkg;

  // Operation codes, numbered in the listed order from zero
  typedef enum logic [5:0] {
    branch_flag_set_indexed, branch_flag_clear_indexed,
    branch_on_equal, branch_on_unequal,
    branch_carry_one, branch_carry_zero,
    branch_same_or_higher, branch_lower,
    branch_negative, branch_positive,
    branch_signed_ge, branch_signed_lt,
    branch_halfcarry_one, branch_halfcarry_zero,
    branch_transfer_one, branch_transfer_zero,
    branch_overflow_one, branch_overflow_zero,
    branch_irq_enabled, branch_irq_disabled,
    io_bit_set,
    shift_left_logical, shift_right_logical,
    rotate_left_carry, rotate_right_carry, shift_right_arith,
    bit_to_transfer_flag, transfer_flag_to_bit,
    carry_force_one, carry_force_zero,
    negative_force_one, negative_force_zero,
    zero_flag_force_one, zero_flag_force_zero,
    irq_global_on, irq_global_off,
    sign_force_one
  } cbb_op_t;

  // Command word as written by software
  typedef struct packed {
    logic [10:0] rsvd;
    cbb_op_t     op;   // Operation
    logic [2:0]  sel;  // Flag index s or bit index b
    logic [4:0]  idx;  // Register Rd/Rr or I/O location P
    logic [6:0]  k;    // Signed branch offset
  } cbb_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_HOLD
  } cbb_state_t;

endpackage

// ===== cbb_exec_unit_sva.sv
// Port checker for the branch and bit-operation unit.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module cbb_exec_unit_sva #(
  parameter int PC_W = 16
) (
  input wire logic            clk_sys,
  input wire logic            rstn,
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_we_i,
  input wire logic [11:0]     wb_adr_i,
  input wire logic [31:0]     wb_dat_i,
  input wire logic [3:0]      wb_sel_i,
  input wire logic [31:0]     wb_dat_o,
  input wire logic            wb_ack_o,
  input wire logic [PC_W-1:0] pc_o,
  input wire logic [7:0]      status_flags_register_o,
  input wire logic            busy_o
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  logic            go;
  logic [5:0]      opc;
  logic [PC_W-1:0] inc_ff;
  logic [PC_W-1:0] tgt_ff;

  // Command accepted at the ack edge while idle
  assign go  = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && !busy_o
               && wb_adr_i == 12'h000 && wb_sel_i[2:0] == 3'h7;
  assign opc = wb_dat_i[20:15];

  // Fall-through and target address of the accepted command
  always_ff @(posedge clk_sys) begin
    if (go) begin
      inc_ff <= pc_o + 1'b1;
      tgt_ff <= pc_o + {{(PC_W-7){wb_dat_i[6]}}, wb_dat_i[6:0]} + 1'b1;
    end
  end

  sequence br_go;
    go && opc <= 6'h13;
  endsequence
  sequence one_cyc;
    busy_o ##1 !busy_o;
  endsequence
  sequence two_cyc;
    busy_o [*2] ##1 !busy_o;
  endsequence
  property flag_p(code, om, am);
    go && opc == code |=> ##1 status_flags_register_o == (($past(status_flags_register_o, 2) | om) & am);
  endproperty

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack late");
  br_len_a: assert property (br_go |=> one_cyc or two_cyc)
    else $error("branch length wrong");
  br_target_a: assert property (br_go |=> ##1
    (busy_o ? pc_o == tgt_ff : pc_o == inc_ff)) else $error("bad pc");
  br_flags_a: assert property (br_go |=> $stable(status_flags_register_o) [*2])
    else $error("branch altered flags");
  io_set_a: assert property (go && opc == 6'h14
    |=> two_cyc and $stable(status_flags_register_o) [*3]) else $error("io set wrong");
  short_len_a: assert property (go && opc >= 6'h15 |=> one_cyc)
    else $error("short op length wrong");
  shift_keep_a: assert property (go && opc inside {[6'h15:6'h19]}
    |=> ##1 status_flags_register_o[7:4] == $past(status_flags_register_o[7:4], 2)) else $error("shift");
  t_only_a: assert property (go && opc == 6'h1A |=> ##1
    (status_flags_register_o & 8'hBF) == ($past(status_flags_register_o, 2) & 8'hBF)) else $error("bit T");
  load_keep_a: assert property (flag_p(6'h1B, 8'h00, 8'hFF))
    else $error("bit load altered flags");
  carry_one_a: assert property (flag_p(6'h1C, 8'h01, 8'hFF))
    else $error("carry force wrong");
  irq_on_a: assert property (flag_p(6'h22, 8'h80, 8'hFF))
    else $error("irq on wrong");
  irq_off_a: assert property (flag_p(6'h23, 8'h00, 8'h7F))
    else $error("irq off wrong");
  sign_one_a: assert property (flag_p(6'h24, 8'h10, 8'hFF))
    else $error("sign force wrong");
endmodule

bind cbb_exec_unit cbb_exec_unit_sva #(.PC_W(PC_W)) u_sva (
  .clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pc_o(pc_o), .status_flags_register_o(status_flags_register_o), .busy_o(busy_o)
);

// ===== tb_cond_branch_and_bit_ops.sv
// Self-checking bench for the branch and bit-operation unit.
// Assumes package, unit and checker are compiled before it.
`timescale 1ns/100ps
module tb_cond_branch_and_bit_ops;
  logic        clk_sys = 1'b0;
  logic        rstn, cyc, stb, we, ack, busy, t;
  logic [11:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0]  sel;
  logic [15:0] pc;
  logic [7:0]  status_flags_register, f, v, e;
  logic [6:0]  k;
  logic [7:0]  pat [4] = '{8'h00, 8'hFF, 8'h55, 8'hAA};
  int          err_total = 0;
  int          cmp_count = 0;

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  cbb_exec_unit u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pc_o(pc), .status_flags_register_o(status_flags_register),
    .busy_o(busy)
  );

  // Verdict and end of run
  task automatic conclude();
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // A wait ran out of its bound
  task automatic hang();
    $display("Error %0t: timeout", $time);
    err_total++;
    conclude();
  endtask

  // Compare one value
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      err_total++;
      $display("Error %0t: got %h exp %h", $time, g, x);
    end
  endtask

  // One classic Wishbone cycle, read data taken at the ack edge
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
      hang();
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Issue a command, then poll the busy bit
  task automatic run(input int op, input logic [2:0] s,
                     input logic [4:0] ix, input logic [6:0] kk);
    cbb_pkg::cbb_cmd_t c;
    int n;
    c = '0;
    c.op = cbb_pkg::cbb_op_t'(op);
    c.sel = s;
    c.idx = ix;
    c.k = kk;
    wb(1'b1, 12'h000, c);
    n = 0;
    do begin
      wb(1'b0, 12'h00C, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 10);
    if (q[0] !== 1'b0)
      hang();
  endtask

  // Expected branch outcome from the flags
  function automatic logic taken(input int op, input logic [2:0] s,
                                 input logic [7:0] x);
    logic c;
    case (op / 2)
      0: c = x[s];
      1: c = x[1];
      2, 3: c = x[0];
      4: c = x[2];
      5: c = x[2] ^ x[3];
      6: c = x[5];
      7: c = x[6];
      8: c = x[3];
      default: c = x[7];
    endcase
    // Odd codes test the cleared sense, except lower and less-than
    return c ^ op[0] ^ (op inside {6, 7, 10, 11});
  endfunction

  // Expected flags and result of a shift or rotate
  function automatic logic [15:0] shf(input int op, input logic [7:0] d,
                                      input logic [7:0] x);
    logic [7:0] r;
    logic c;
    case (op)
      21: {c, r} = {d, 1'b0};
      22: {r, c} = {1'b0, d};
      23: {c, r} = {d, x[0]};
      24: {r, c} = {x[0], d};
      default: {r, c} = {d[7], d};
    endcase
    x[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
    return {x, r};
  endfunction

  // Expected flags after a single-flag instruction
  function automatic logic [7:0] flg(input int op, input logic [7:0] x);
    int fi [4] = '{0, 2, 1, 7};
    if (op == 36)
      x[4] = 1'b1;
    else
      x[fi[(op - 28) / 2]] = !op[0];
    return x;
  endfunction

  initial begin
    rstn <= 1'b0;
    cyc  <= 1'b0;
    stb  <= 1'b0;
    we   <= 1'b0;
    adr  <= 12'h000;
    wdat <= 32'h0;
    sel  <= 4'hF;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    // Reset state and an unmapped place
    wb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 12'h008, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, 12'h300, 32'hFF);
    wb(1'b0, 12'h300, 32'h0);
    chk(q, 32'h0);
    // Every branch against four flag patterns, both offset signs
    for (int op = 0; op < 20; op++) begin
      for (int j = 0; j < 4; j++) begin
        f = pat[j];
        k = j[0] ? 7'h7D : 7'h05;
        t = taken(op, 3'(op + j), f);
        wb(1'b1, 12'h004, {24'h0, f});
        wb(1'b1, 12'h008, 32'h40);
        run(op, 3'(op + j), 5'h00, k);
        chk(q, {30'h0, t, 1'b0});
        wb(1'b0, 12'h008, 32'h0);
        chk(q, t ? 32'h41 + {{25{k[6]}}, k} : 32'h41);
        chk({16'h0, pc}, t ? 32'h41 + {{25{k[6]}}, k} : 32'h41);
        wb(1'b0, 12'h004, 32'h0);
        chk(q, {24'h0, f});
        chk({24'h0, status_flags_register}, {24'h0, f});
      end
    end
    // Shifts and rotates on two operands with opposite flags
    for (int op = 21; op < 26; op++) begin
      for (int j = 0; j < 2; j++) begin
        v = j ? 8'h80 : 8'h41;
        f = j ? 8'h00 : 8'hFF;
        wb(1'b1, 12'h004, {24'h0, f});
        wb(1'b1, 12'h10C, {24'h0, v});
        run(op, 3'h0, 5'h03, 7'h00);
        {e, v} = shf(op, v, f);
        wb(1'b0, 12'h10C, 32'h0);
        chk(q, {24'h0, v});
        wb(1'b0, 12'h004, 32'h0);
        chk(q, {24'h0, e});
      end
    end
    // Set bit 3 of I/O location 5, two cycles, flags kept
    wb(1'b1, 12'h004, 32'hA5);
    wb(1'b1, 12'h008, 32'h10);
    wb(1'b1, 12'h214, 32'h21);
    run(20, 3'h3, 5'h05, 7'h00);
    wb(1'b0, 12'h214, 32'h0);
    chk(q, 32'h29);
    wb(1'b0, 12'h004, 32'h0);
    chk(q, 32'hA5);
    chk({16'h0, pc}, 32'h11);
    chk({31'h0, busy}, 32'h0);
    // Register bit into T both ways, with T copied into another register in between
    wb(1'b1, 12'h11C, 32'hA5);
    run(26, 3'h2, 5'h07, 7'h00);
    wb(1'b0, 12'h004, 32'h0);
    chk(q, 32'hE5);
    run(27, 3'h6, 5'h08, 7'h00);
    wb(1'b0, 12'h120, 32'h0);
    chk(q, 32'h40);
    run(26, 3'h1, 5'h07, 7'h00);
    wb(1'b0, 12'h004, 32'h0);
    chk(q, 32'hA5);
    // Single-flag forcing from opposite starting patterns
    for (int op = 28; op < 37; op++) begin
      for (int j = 0; j < 2; j++) begin
        f = j ? 8'h5A : 8'hA5;
        wb(1'b1, 12'h004, {24'h0, f});
        run(op, 3'h0, 5'h00, 7'h00);
        wb(1'b0, 12'h004, 32'h0);
        chk(q, {24'h0, flg(op, f)});
      end
    end
    // Unknown code only advances the program counter
    wb(1'b1, 12'h008, 32'h20);
    run(37, 3'h0, 5'h00, 7'h00);
    wb(1'b0, 12'h008, 32'h0);
    chk(q, 32'h21);
    // Command word reads back as written
    wb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h0012_8000);
    conclude();
  end
endmodule
